/* File: core/pio_pkg.sv */
`default_nettype none
package pio_pkg;
   localparam int NUM_BANKS = 8;
   localparam int BANK_WIDTH = 8;
   localparam int ADDR_WIDTH = 8;
   localparam int IDX_WIDTH = 4;

   typedef logic [BANK_WIDTH-1:0] pio_byte_t;
   typedef logic [NUM_BANKS-1:0][BANK_WIDTH-1:0] pio_pins_t;
   typedef logic [IDX_WIDTH-1:0] pio_idx_t;

   // Register indices; byte address is four times the index
   localparam pio_idx_t IDX_BANK_A_PIN_LATCH = 4'h0;
   localparam pio_idx_t IDX_BANK_B_PIN_LATCH = 4'h1;
   localparam pio_idx_t IDX_BANK_C_PIN_LATCH = 4'h2;
   localparam pio_idx_t IDX_BANK_D_PIN_LATCH = 4'h3;
   localparam pio_idx_t IDX_BANK_A_DIRECTION = 4'h4;
   localparam pio_idx_t IDX_BANK_B_DIRECTION = 4'h5;
   localparam pio_idx_t IDX_BANK_C_DIRECTION = 4'h6;
   localparam pio_idx_t IDX_BANK_D_DIRECTION = 4'h7;
   localparam pio_idx_t IDX_BANK_E_PIN_LATCH = 4'h8;
   localparam pio_idx_t IDX_BANK_F_PIN_LATCH = 4'h9;
   localparam pio_idx_t IDX_BANK_G_PIN_LATCH = 4'ha;
   localparam pio_idx_t IDX_BANK_H_PIN_LATCH = 4'hb;
   localparam pio_idx_t IDX_BANK_E_DIRECTION = 4'hc;
   localparam pio_idx_t IDX_BANK_F_DIRECTION = 4'hd;
   localparam pio_idx_t IDX_BANK_G_DIRECTION = 4'he;
   localparam pio_idx_t IDX_BANK_H_DIRECTION = 4'hf;

   localparam pio_idx_t LATCH_IDX [NUM_BANKS] = '{
      IDX_BANK_A_PIN_LATCH, IDX_BANK_B_PIN_LATCH, IDX_BANK_C_PIN_LATCH, IDX_BANK_D_PIN_LATCH,
      IDX_BANK_E_PIN_LATCH, IDX_BANK_F_PIN_LATCH, IDX_BANK_G_PIN_LATCH, IDX_BANK_H_PIN_LATCH};
   localparam pio_idx_t DIR_IDX [NUM_BANKS] = '{
      IDX_BANK_A_DIRECTION, IDX_BANK_B_DIRECTION, IDX_BANK_C_DIRECTION, IDX_BANK_D_DIRECTION,
      IDX_BANK_E_DIRECTION, IDX_BANK_F_DIRECTION, IDX_BANK_G_DIRECTION, IDX_BANK_H_DIRECTION};

   // Implemented pins per bank, A first
   localparam pio_byte_t BANK_MASK [NUM_BANKS] = '{
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'h0f};

   localparam pio_byte_t DIR_RESET = 8'h00;
endpackage : pio_pkg
`default_nettype wire

/* File: core/pio_bank_if.sv */
`default_nettype none
interface pio_bank_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] wrData;
   logic latchWe;
   logic dirWe;
   logic [WIDTH-1:0] pinSync;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] dir;
   logic [WIDTH-1:0] rdData;

   modport ctrl (output wrData, output latchWe, output dirWe, output pinSync,
                 input latch, input dir, input rdData);
   modport bank (input wrData, input latchWe, input dirWe, input pinSync,
                 output latch, output dir, output rdData);
endinterface : pio_bank_if
`default_nettype wire

/* File: core/pio_sync.sv */
`default_nettype none
module pio_sync #(parameter int WIDTH = 8)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds the second stage only
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule : pio_sync
`default_nettype wire

/* File: core/pio_bank.sv */
`default_nettype none
module pio_bank
   import pio_pkg::*;
#(
   parameter pio_byte_t MASK = 8'hff
)
(
   input wire logic clk,
   input wire logic reset,
   pio_bank_if.bank bus
);
   pio_byte_t latch_ff;
   pio_byte_t dir_ff;
   pio_byte_t nxt_latch;
   pio_byte_t nxt_dir;

   // Unimplemented bits never store, so they read back as zero
   assign nxt_latch = bus.wrData & MASK;
   assign nxt_dir = bus.wrData & MASK;

   // No reset term: the latch keeps its contents across reset
   always_ff @(posedge clk)
   begin
      if (bus.latchWe)
         latch_ff <= nxt_latch;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         dir_ff <= DIR_RESET;
      else if (bus.dirWe)
         dir_ff <= nxt_dir;
   end

   assign bus.latch = latch_ff;
   assign bus.dir = dir_ff;
   // Output pins read the latch, input pins read the synchronised level
   assign bus.rdData = ((dir_ff & latch_ff) | (~dir_ff & bus.pinSync)) & MASK;
endmodule : pio_bank
`default_nettype wire

/* File: core/pio_ports.sv */
// The APB slave port was left to the implementer.
`default_nettype none
// What this block does
// - Bank A has eight two-way pins with a latch and a direction register.
// - Bank B has the same eight pins, latch and direction register as A.
// - Each pin's direction follows the same-position bit of its bank's direction register.
// - Direction one enables the pin driver; zero leaves the pin an undriven input.
// - Reset clears all direction bits so every pin starts as input.
// - Reset leaves every data latch unchanged.
// - Reading data returns the latch for pins set as outputs.
// - Reading data returns the sampled pin level for pins set as inputs.
// - Data writes with pstrb[0] set load the latches, whatever the direction bits say.
// - Bank A latch sits at index 0, its direction at index 4.
// - Bank B latch sits at index 1, its direction at index 5.
// - Bank F has six pins; bits 7 and 6 read zero.
// - Banks G and H have four pins; bits 7 to 4 read zero.
module pio_ports
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pio_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pio_pkg::pio_pins_t pinIn,
   output pio_pkg::pio_pins_t pinOut,
   output pio_pkg::pio_pins_t pinOe
);
   import pio_pkg::*;

   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] nxt_prdata;
   logic nxt_pslverr;

   pio_pins_t pinSync;
   pio_idx_t regIdx;
   logic addrMapped;
   logic accessPhase;
   logic answerCycle;
   logic writeDone;
   pio_byte_t rdChain [NUM_BANKS+1];
   logic [NUM_BANKS:0] hitChain;

   // Pins come from another domain
   pio_sync #(.WIDTH(NUM_BANKS*BANK_WIDTH)) pinSyncInst
   (
      .clk(clk),
      .reset(reset),
      .d(pinIn),
      .q(pinSync)
   );

   // Word-aligned decode; anything above the sixteen words is unmapped
   assign regIdx = paddr[IDX_WIDTH+1:2];
   assign addrMapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:IDX_WIDTH+2] == '0);
   assign accessPhase = psel && penable;
   // One wait state: the answer is prepared while pready is low
   assign answerCycle = accessPhase && !pready_ff;
   // Writes commit only on the edge where the master sees pready
   assign writeDone = accessPhase && pready_ff && pwrite && addrMapped && pstrb[0];

   assign rdChain[0] = '0;
   assign hitChain[0] = 1'b0;

   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : gBank
      pio_bank_if #(.WIDTH(BANK_WIDTH)) bankBus ();
      logic hitLatch;
      logic hitDir;

      assign hitLatch = addrMapped && (regIdx == LATCH_IDX[b]);
      assign hitDir = addrMapped && (regIdx == DIR_IDX[b]);
      assign bankBus.wrData = pwdata[BANK_WIDTH-1:0];
      assign bankBus.latchWe = writeDone && hitLatch;
      assign bankBus.dirWe = writeDone && hitDir;
      assign bankBus.pinSync = pinSync[b];

      // Direction reads are masked inside the bank already
      assign rdChain[b+1] = rdChain[b]
                            | (hitLatch ? bankBus.rdData : 8'h00)
                            | (hitDir ? bankBus.dir : 8'h00);
      assign hitChain[b+1] = hitChain[b] | hitLatch | hitDir;

      pio_bank #(.MASK(BANK_MASK[b])) bankInst
      (
         .clk(clk),
         .reset(reset),
         .bus(bankBus.bank)
      );

      assign pinOut[b] = bankBus.latch;
      assign pinOe[b] = bankBus.dir;
   end

   assign nxt_prdata = {24'h000000, rdChain[NUM_BANKS]};
   assign nxt_pslverr = !hitChain[NUM_BANKS];

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end
      else
      begin
         pready_ff <= answerCycle;
         pslverr_ff <= answerCycle && nxt_pslverr;
         prdata_ff <= (answerCycle && !pwrite) ? nxt_prdata : 32'h00000000;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
endmodule : pio_ports
`default_nettype wire

/* File: sim/pio_board.sv */
`default_nettype none
module pio_board
(
   input wire pio_pkg::pio_pins_t boardVal,
   input wire pio_pkg::pio_pins_t pinOut,
   input wire pio_pkg::pio_pins_t pinOe,
   output pio_pkg::pio_pins_t pinIn
);
   timeunit 1ns;
   timeprecision 100ps;
   // Device buffer wins where enabled
   assign pinIn = (pinOe & pinOut) | (~pinOe & boardVal);
endmodule : pio_board
`default_nettype wire

/* File: sim/pio_ports_checker.sv */
`default_nettype none
module pio_ports_checker
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pio_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pio_pkg::pio_pins_t pinOut,
   input wire pio_pkg::pio_pins_t pinOe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire logic wrDone = psel && penable && pready && pwrite && pstrb[0];
   a_one_wait: assert property (psel && penable && !pready |=> pready &&
      pslverr == (($past(paddr) & 8'hc3) != 8'h00)) else $error("bad answer");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
   a_rd_idle: assert property (!pready |-> prdata == 32'h0) else $error("rd idle");
   a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper");
   a_oe_reset: assert property ($fell(reset) |-> pinOe == '0) else $error("oe");
   a_short_banks: assert property (pinOe[5][7:6] == 2'h0 && pinOe[6][7:4] == 4'h0
      && pinOe[7][7:4] == 4'h0) else $error("short bank oe");
   a_dir_a: assert property (wrDone && paddr == 8'h10 |=> pinOe[0] == 8'($past(pwdata)))
      else $error("dir a");
   a_latch_b: assert property (wrDone && paddr == 8'h04 |=> pinOut[1] == 8'($past(pwdata)))
      else $error("latch b");
   a_oe_hold: assert property (!wrDone |=> $stable(pinOe)) else $error("oe moved");
endmodule : pio_ports_checker
bind pio_ports pio_ports_checker u_checker (.clk, .reset, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .pinOut, .pinOe);
`default_nettype wire

/* File: sim/test_parallel_io_ports.sv */
`default_nettype none
module test_parallel_io_ports;
   timeunit 1ns;
   timeprecision 100ps;
   import pio_pkg::*;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready, err;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   pio_pins_t pinIn, pinOut, pinOe;
   pio_pins_t boardVal = {8{8'h3c}};
   int n_errors = 0, comparisons = 0, cycles = 0;
   pio_ports uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe);
   pio_board board (.boardVal, .pinOut, .pinOe, .pinIn);
   initial forever #12.5 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'hffffff, d};
      @(posedge clk);
      penable <= 1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic s_banks;
      logic [7:0] m, la, da;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         m = BANK_MASK[b];
         la = {2'b00, LATCH_IDX[b], 2'b00};
         da = {2'b00, DIR_IDX[b], 2'b00};
         apb(1, la, 8'ha5);
         apb(0, la, 8'h0);
         check(rd[7:0], boardVal[b] & m);
         apb(1, da, 8'hff);
         apb(0, da, 8'h0);
         check(rd[7:0], m);
         check(pinOe[b], m);
         check(pinOut[b] & m, 8'ha5 & m);
         apb(0, la, 8'h0);
         check(rd[7:0], 8'ha5 & m);
         apb(1, da, 8'h0f);
         apb(0, la, 8'h0);
         check(rd[7:0], (8'h05 | boardVal[b] & 8'hf0) & m);
      end
   endtask : s_banks
   task automatic s_reset;
      apb(1, 8'h14, 8'hff);
      apb(1, 8'h00, 8'h96);
      pstrb <= 4'he;
      apb(1, 8'h00, 8'h11);
      pstrb <= 4'hf;
      check(pinOut[0], 8'h96);
      @(posedge clk);
      reset <= 1;
      @(posedge clk);
      reset <= 0;
      check(pinOe[1], 8'h00);
      check(pinOut[0], 8'h96);
      boardVal <= {8{8'h5a}};
      apb(0, 8'h00, 8'h0);
      check(rd[7:0], 8'h5a);
      apb(0, 8'h14, 8'h0);
      check(rd[7:0], 8'h00);
      apb(0, 8'h41, 8'h0);
      check({7'h0, err}, 8'h01);
      apb(1, 8'h40, 8'h0);
      check({7'h0, err}, 8'h01);
   endtask : s_reset
   task automatic tally_and_finish;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 0;
      s_banks();
      s_reset();
      tally_and_finish();
   end
endmodule : test_parallel_io_ports
`default_nettype wire
